// ---- crt_pins_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module crt_pins_model (
  input wire logic pclk,
  output var logic trigger_pin,
  output var logic external_count_pin,
  output var logic other_timer_ovf
);
  // pins idle high as with pull-ups, so no false falling edge after reset
  initial begin
    trigger_pin = 1'b1;
    external_count_pin = 1'b1;
    other_timer_ovf = 1'b0;
  end
  // level stays put afterwards: it is also the count direction
  task automatic trig(input logic v);
    @(posedge pclk);
    trigger_pin <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic cnt_pulse;
    @(posedge pclk);
    external_count_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    external_count_pin <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic ovf_pulse;
    @(posedge pclk);
    other_timer_ovf <= 1'b1;
    @(posedge pclk);
    other_timer_ovf <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- crt_pkg.sv ----
package crt_pkg;

  typedef struct packed {
    logic ovf_flag;
    logic ext_flag;
    logic rx_baud_sel;
    logic tx_baud_sel;
    logic ext_trig_en;
    logic run;
    logic cnt_sel;
    logic cap_sel;
  } crt_ctrl_t;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic       cap_reset_en;
    logic [1:0] rsvd_lo;
    logic       down_en;
  } crt_mode_t;

  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
  } crt_baud_t;

  typedef enum logic [2:0] {
    CRT_RELOAD  = 3'b001,
    CRT_CAPTURE = 3'b010,
    CRT_BAUD    = 3'b100
  } crt_func_t;

endpackage

// ---- crt_regs.svh ----
`ifndef CRT_REGS_SVH
`define CRT_REGS_SVH

// register indices; the byte address is four times the index
`define CRT_IDX_CTRL      8'hc8
`define CRT_IDX_MODE      8'hc9
`define CRT_IDX_RCAP_LO   8'hca
`define CRT_IDX_RCAP_HI   8'hcb
`define CRT_IDX_CNT_LO    8'hcc
`define CRT_IDX_CNT_HI    8'hcd
`define CRT_IDX_MISC      8'hce

// reset values
`define CRT_RST_CTRL      8'h00
`define CRT_RST_MODE      8'h00
`define CRT_RST_RCAP      16'h0000
`define CRT_RST_CNT       16'h0000
`define CRT_RST_MISC      8'h00

// writable bits of the mode register
`define CRT_MODE_WMASK    8'h09

// field positions of the misc register
`define CRT_MISC_IRQ_EN   0
`define CRT_MISC_PRIO     1
`define CRT_MISC_DIV_SEL  2

// timer prescale, in clocks per tick
`define CRT_DIV_SLOW      4'hc
`define CRT_DIV_FAST      4'h4
`define CRT_BAUD_CLKS     2

`endif

// ---- crt_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "crt_regs.svh"

module crt_timer (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                trigger_pin,
  input  wire logic                external_count_pin,
  input  wire logic                other_timer_ovf,
  input  wire logic [1:0]          serial_mode,
  output crt_pkg::crt_baud_t       baud_tick,
  output logic                     timer_irq_req,
  output logic                     timer_irq_high_prio
);
  import crt_pkg::*;

  function automatic logic crt_hit(
    input logic [11:0] a,
    input logic [7:0]  idx
  );
    crt_hit = (a == {2'h0, idx, 2'h0});
  endfunction

  // pin synchronisers: [0] trigger, [1] count pin
  logic [1:0] pin_raw;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] pin_fall;

  assign pin_raw = {external_count_pin, trigger_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
          sync3_q[gi] <= 1'b1;
        end else if (clk_en) begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
        end
      end
      assign pin_fall[gi] = sync3_q[gi] & ~sync2_q[gi];
    end
  endgenerate

  logic trig_fall;
  logic trig_lvl;
  logic cnt_fall;

  assign trig_fall = pin_fall[0];
  assign trig_lvl  = sync2_q[0];
  assign cnt_fall  = pin_fall[1];

  crt_ctrl_t   ctrl_q;
  crt_ctrl_t   ctrl_d;
  crt_mode_t   mode_q;
  crt_mode_t   mode_d;
  logic [15:0] rcap_q;
  logic [15:0] rcap_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [7:0]  misc_q;
  logic [7:0]  misc_d;
  logic [3:0]  pre_q;
  logic [3:0]  pre_d;
  logic        half_q;
  logic        half_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  crt_baud_t   baud_q;
  crt_baud_t   baud_d;

  crt_func_t   func;
  logic        wr;
  logic        setup;
  logic        hit_any;
  logic        tick;
  logic        count_down;
  logic        own_ovf;
  logic        ovf_set;
  logic        ext_set;
  logic        trig_act;
  logic [3:0]  pre_max;
  logic [7:0]  rd_val;

  always_comb begin
    if (ctrl_q.rx_baud_sel || ctrl_q.tx_baud_sel) begin
      func = CRT_BAUD;
    end else if (ctrl_q.cap_sel) begin
      func = CRT_CAPTURE;
    end else begin
      func = CRT_RELOAD;
    end
  end

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & clk_en;
  assign hit_any = crt_hit(paddr, `CRT_IDX_CTRL)
                 | crt_hit(paddr, `CRT_IDX_MODE)
                 | crt_hit(paddr, `CRT_IDX_RCAP_LO)
                 | crt_hit(paddr, `CRT_IDX_RCAP_HI)
                 | crt_hit(paddr, `CRT_IDX_CNT_LO)
                 | crt_hit(paddr, `CRT_IDX_CNT_HI)
                 | crt_hit(paddr, `CRT_IDX_MISC);

  // a frozen block cannot finish a transfer, so pready follows the enable
  assign pready  = clk_en;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_q;

  always_comb begin
    ctrl_d     = ctrl_q;
    mode_d     = mode_q;
    rcap_d     = rcap_q;
    cnt_d      = cnt_q;
    misc_d     = misc_q;
    pre_d      = pre_q;
    half_d     = half_q;
    prdata_d   = prdata_q;
    baud_d     = '0;
    tick       = 1'b0;
    own_ovf    = 1'b0;
    ovf_set    = 1'b0;
    ext_set    = 1'b0;
    rd_val     = 8'h00;
    pre_max    = misc_q[`CRT_MISC_DIV_SEL] ? (`CRT_DIV_FAST - 4'h1)
                                           : (`CRT_DIV_SLOW - 4'h1);
    count_down = (func == CRT_RELOAD) && mode_q.down_en
                 && !trig_lvl;
    trig_act   = trig_fall && ctrl_q.ext_trig_en
                 && (func != CRT_BAUD);

    // tick source; nothing advances while run is clear
    if (ctrl_q.run) begin
      if (func == CRT_BAUD) begin
        half_d = ~half_q;
        tick   = half_q;
      end else if (ctrl_q.cnt_sel) begin
        tick = cnt_fall;
      end else if (pre_q >= pre_max) begin
        pre_d = 4'h0;
        tick  = 1'b1;
      end else begin
        pre_d = pre_q + 4'h1;
      end
    end

    if (tick) begin
      if (count_down) begin
        if (cnt_q == rcap_q) begin
          cnt_d   = 16'hffff;
          own_ovf = 1'b1;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end else if (cnt_q == 16'hffff) begin
        own_ovf = 1'b1;
        if (func == CRT_CAPTURE) begin
          cnt_d = 16'h0000;
        end else begin
          cnt_d = rcap_q;
        end
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end

    if (own_ovf && (func != CRT_BAUD)) begin
      ovf_set = 1'b1;
    end
    // with down counting the trigger pin steers direction, so overflow marks it instead
    if (own_ovf && (func == CRT_RELOAD) && mode_q.down_en) begin
      ext_set = 1'b1;
    end

    if (trig_act) begin
      if (func == CRT_CAPTURE) begin
        rcap_d  = cnt_q;
        ext_set = 1'b1;
        if (mode_q.cap_reset_en) begin
          cnt_d = 16'h0000;
        end
      end else if (!mode_q.down_en) begin
        cnt_d   = rcap_q;
        ext_set = 1'b1;
      end
    end

    // software writes override hardware updates, except flag sets
    if (wr && crt_hit(paddr, `CRT_IDX_CTRL)) begin
      ctrl_d = crt_ctrl_t'(pwdata[7:0]);
    end
    if (wr && crt_hit(paddr, `CRT_IDX_MODE)) begin
      mode_d = crt_mode_t'(pwdata[7:0] & `CRT_MODE_WMASK);
    end
    if (wr && crt_hit(paddr, `CRT_IDX_RCAP_LO)) begin
      rcap_d[7:0] = pwdata[7:0];
    end
    if (wr && crt_hit(paddr, `CRT_IDX_RCAP_HI)) begin
      rcap_d[15:8] = pwdata[7:0];
    end
    if (wr && crt_hit(paddr, `CRT_IDX_CNT_LO)) begin
      cnt_d[7:0] = pwdata[7:0];
    end
    if (wr && crt_hit(paddr, `CRT_IDX_CNT_HI)) begin
      cnt_d[15:8] = pwdata[7:0];
    end
    if (wr && crt_hit(paddr, `CRT_IDX_MISC)) begin
      misc_d = {5'h00, pwdata[2:0]};
    end

    // a hardware set in the same cycle as a clear wins
    ctrl_d.ovf_flag = ctrl_d.ovf_flag | ovf_set;
    ctrl_d.ext_flag = ctrl_d.ext_flag | ext_set;

    if (crt_hit(paddr, `CRT_IDX_CTRL)) begin
      rd_val = ctrl_q;
    end else if (crt_hit(paddr, `CRT_IDX_MODE)) begin
      rd_val = mode_q;
    end else if (crt_hit(paddr, `CRT_IDX_RCAP_LO)) begin
      rd_val = rcap_q[7:0];
    end else if (crt_hit(paddr, `CRT_IDX_RCAP_HI)) begin
      rd_val = rcap_q[15:8];
    end else if (crt_hit(paddr, `CRT_IDX_CNT_LO)) begin
      rd_val = cnt_q[7:0];
    end else if (crt_hit(paddr, `CRT_IDX_CNT_HI)) begin
      rd_val = cnt_q[15:8];
    end else if (crt_hit(paddr, `CRT_IDX_MISC)) begin
      rd_val = misc_q;
    end
    // read data is latched in the setup cycle, one clock before completion
    if (setup) begin
      prdata_d = {24'h000000, rd_val};
    end

    // baud clocks only feed serial modes 1 and 3
    if (serial_mode[0]) begin
      baud_d.rx_tick = ctrl_q.rx_baud_sel ? own_ovf : other_timer_ovf;
      baud_d.tx_tick = ctrl_q.tx_baud_sel ? own_ovf : other_timer_ovf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= crt_ctrl_t'(`CRT_RST_CTRL);
      mode_q   <= crt_mode_t'(`CRT_RST_MODE);
      rcap_q   <= `CRT_RST_RCAP;
      cnt_q    <= `CRT_RST_CNT;
      misc_q   <= `CRT_RST_MISC;
      pre_q    <= 4'h0;
      half_q   <= 1'b0;
      prdata_q <= 32'h00000000;
      baud_q   <= '0;
    end else if (clk_en) begin
      ctrl_q   <= ctrl_d;
      mode_q   <= mode_d;
      rcap_q   <= rcap_d;
      cnt_q    <= cnt_d;
      misc_q   <= misc_d;
      pre_q    <= pre_d;
      half_q   <= half_d;
      prdata_q <= prdata_d;
      baud_q   <= baud_d;
    end
  end

  assign baud_tick           = baud_q;
  assign timer_irq_req       = misc_q[`CRT_MISC_IRQ_EN]
                               & (ctrl_q.ovf_flag | ctrl_q.ext_flag);
  assign timer_irq_high_prio = misc_q[`CRT_MISC_PRIO];

endmodule
`default_nettype wire

// ---- crt_timer_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module crt_timer_sva (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               clk_en,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               other_timer_ovf,
  input wire logic [1:0]         serial_mode,
  input wire crt_pkg::crt_baud_t baud_tick,
  input wire logic               timer_irq_req,
  input wire logic               timer_irq_high_prio
);
  import crt_pkg::*;
  // shadow of software-only bits: {rx_sel, tx_sel, irq_en, prio}
  logic [3:0] sh_q;
  logic [3:0] sh_d;
  logic       wr;
  assign wr = psel & penable & pwrite & clk_en;
  always_comb begin
    sh_d = sh_q;
    if (wr && paddr == 12'h320) sh_d[3:2] = pwdata[5:4];
    if (wr && paddr == 12'h338) sh_d[1:0] = {pwdata[0], pwdata[1]};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh_q <= 4'h0;
    else sh_q <= sh_d;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctrl_wr;
    wr && paddr == 12'h320;
  endsequence
  sequence s_ext_set;
    s_ctrl_wr ##0 (pwdata[6] && sh_q[1]);
  endsequence
  AST_RX_OTHER: assert property (
    other_timer_ovf && serial_mode[0] && !sh_q[3] && clk_en |=> baud_tick.rx_tick)
    else $error("rx tick missing after other timer overflow");
  AST_TX_OTHER: assert property (
    other_timer_ovf && serial_mode[0] && !sh_q[2] && clk_en |=> baud_tick.tx_tick)
    else $error("tx tick missing after other timer overflow");
  AST_RX_SRC: assert property (
    baud_tick.rx_tick |-> $past(serial_mode[0]) && ($past(sh_q[3]) || $past(other_timer_ovf)))
    else $error("rx tick from wrong source");
  AST_TX_SRC: assert property (
    baud_tick.tx_tick |-> $past(serial_mode[0]) && ($past(sh_q[2]) || $past(other_timer_ovf)))
    else $error("tx tick from wrong source");
  AST_TICK_GAP: assert property (
    baud_tick.rx_tick && sh_q[3] |=> !baud_tick.rx_tick)
    else $error("own baud ticks closer than two clocks");
  AST_IRQ_GATE: assert property (
    timer_irq_req |-> sh_q[1])
    else $error("interrupt request while disabled");
  AST_PRIO: assert property (
    1'b1 |-> timer_irq_high_prio == sh_q[0])
    else $error("priority level differs from written bit");
  AST_SW_EXT: assert property (
    s_ext_set |=> timer_irq_req)
    else $error("software external flag set gave no request");
endmodule
bind crt_timer crt_timer_sva chk_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .other_timer_ovf, .serial_mode, .baud_tick, .timer_irq_req,
  .timer_irq_high_prio);
`default_nettype wire

// ---- crt_timer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "crt_regs.svh"
module crt_timer_test;
  import crt_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig;
  logic        cpin;
  logic        oovf;
  logic [1:0]  serial_mode;
  crt_baud_t   baud_tick;
  logic        irq;
  logic        hp;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          n_tests;
  int          n;
  crt_timer dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_pin(trig), .external_count_pin(cpin),
    .other_timer_ovf(oovf), .serial_mode(serial_mode), .baud_tick(baud_tick),
    .timer_irq_req(irq), .timer_irq_high_prio(hp));
  crt_pins_model m (.pclk(pclk), .trigger_pin(trig), .external_count_pin(cpin),
    .other_timer_ovf(oovf));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      n_mismatch++;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for pready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic wtick(output int c);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (baud_tick.rx_tick !== 1'b1 && c < 200);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, serial_mode} = '0;
    clk_en = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`CRT_IDX_CTRL, `CRT_RST_CTRL);
    rdc(`CRT_IDX_MISC, `CRT_RST_MISC);
    wr(`CRT_IDX_MODE, 8'hff);
    rdc(`CRT_IDX_MODE, `CRT_MODE_WMASK);
    wr(`CRT_IDX_MODE, 8'h00);
    xfer(1'b0, 8'hcf, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("register test done");
    wr(`CRT_IDX_MISC, 8'h01);
    wr(`CRT_IDX_RCAP_LO, 8'h34);
    wr(`CRT_IDX_RCAP_HI, 8'h12);
    wr(`CRT_IDX_CNT_LO, 8'hff);
    wr(`CRT_IDX_CNT_HI, 8'hff);
    wr(`CRT_IDX_CTRL, 8'h06);
    m.cnt_pulse();
    rdc(`CRT_IDX_CNT_LO, 8'h34);
    rdc(`CRT_IDX_CNT_HI, 8'h12);
    rdc(`CRT_IDX_CTRL, 8'h86);
    chk({31'h0, irq}, 32'h1);
    wr(`CRT_IDX_CTRL, 8'h00);
    m.cnt_pulse();
    rdc(`CRT_IDX_CTRL, 8'h00);
    rdc(`CRT_IDX_CNT_LO, 8'h34);
    $display("overflow test done");
    wr(`CRT_IDX_CNT_LO, 8'h00);
    wr(`CRT_IDX_CNT_HI, 8'h00);
    wr(`CRT_IDX_CTRL, 8'h06);
    m.trig(1'b0);
    m.trig(1'b1);
    rdc(`CRT_IDX_CNT_HI, 8'h00);
    wr(`CRT_IDX_CTRL, 8'h0e);
    m.trig(1'b0);
    m.trig(1'b1);
    rdc(`CRT_IDX_CNT_HI, 8'h12);
    rdc(`CRT_IDX_CTRL, 8'h4e);
    chk({31'h0, irq}, 32'h1);
    wr(`CRT_IDX_CNT_LO, 8'h78);
    wr(`CRT_IDX_CNT_HI, 8'h56);
    wr(`CRT_IDX_MODE, 8'h08);
    wr(`CRT_IDX_CTRL, 8'h0f);
    m.trig(1'b0);
    m.trig(1'b1);
    rdc(`CRT_IDX_RCAP_LO, 8'h78);
    rdc(`CRT_IDX_RCAP_HI, 8'h56);
    rdc(`CRT_IDX_CNT_LO, 8'h00);
    rdc(`CRT_IDX_CNT_HI, 8'h00);
    $display("trigger test done");
    wr(`CRT_IDX_CNT_LO, 8'h78);
    wr(`CRT_IDX_CNT_HI, 8'h56);
    wr(`CRT_IDX_MODE, 8'h01);
    wr(`CRT_IDX_CTRL, 8'h06);
    m.trig(1'b0);
    m.cnt_pulse();
    rdc(`CRT_IDX_CNT_HI, 8'hff);
    rdc(`CRT_IDX_CTRL, 8'hc6);
    m.cnt_pulse();
    rdc(`CRT_IDX_CNT_LO, 8'hfe);
    m.trig(1'b1);
    m.cnt_pulse();
    rdc(`CRT_IDX_CNT_LO, 8'hff);
    wr(`CRT_IDX_MODE, 8'h00);
    $display("down count test done");
    serial_mode <= 2'h3;
    wr(`CRT_IDX_RCAP_LO, 8'hf0);
    wr(`CRT_IDX_RCAP_HI, 8'hff);
    wr(`CRT_IDX_CTRL, 8'h26);
    wtick(n);
    wtick(n);
    chk(n, 32);
    rdc(`CRT_IDX_CTRL, 8'h26);
    wr(`CRT_IDX_CTRL, 8'h00);
    m.ovf_pulse();
    @(negedge pclk);
    chk({30'h0, baud_tick}, 32'h3);
    @(posedge pclk);
    serial_mode <= 2'h2;
    m.ovf_pulse();
    @(negedge pclk);
    chk({30'h0, baud_tick}, 32'h0);
    $display("baud test done");
    // fast prescale, with a 20-clock freeze in the middle of the run
    wr(`CRT_IDX_MISC, 8'h07);
    wr(`CRT_IDX_CNT_LO, 8'h00);
    chk({31'h0, hp}, 32'h1);
    wr(`CRT_IDX_CNT_HI, 8'h00);
    wr(`CRT_IDX_CTRL, 8'h04);
    repeat (10) @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    chk({31'h0, pready}, 32'h0);
    repeat (19) @(posedge pclk);
    clk_en <= 1'b1;
    repeat (10) @(posedge pclk);
    wr(`CRT_IDX_CTRL, 8'h00);
    rdc(`CRT_IDX_CNT_LO, 8'h05);
    wr(`CRT_IDX_MISC, 8'h03);
    wr(`CRT_IDX_CNT_LO, 8'h00);
    chk({31'h0, hp}, 32'h1);
    wr(`CRT_IDX_CTRL, 8'h04);
    repeat (40) @(posedge pclk);
    wr(`CRT_IDX_CTRL, 8'h00);
    rdc(`CRT_IDX_CNT_LO, 8'h03);
    wr(`CRT_IDX_CTRL, 8'h40);
    rdc(`CRT_IDX_CTRL, 8'h40);
    chk({31'h0, irq}, 32'h1);
    wr(`CRT_IDX_CTRL, 8'h00);
    rdc(`CRT_IDX_CTRL, 8'h00);
    chk({31'h0, irq}, 32'h0);
    $display("timer test done");
    print_verdict();
  end
endmodule
`default_nettype wire
